/* File: fsu_consts.vh */
// Offsets, fields, encodings and reset values of the serial unit.
`ifndef FSU_CONSTS_VH
`define FSU_CONSTS_VH

// ------------------------------------------------------------------
// Register offsets on the register port
// ------------------------------------------------------------------
`define FSU_ADDR_DATA      2'h0
`define FSU_ADDR_STATUS    2'h1
`define FSU_ADDR_CONTROL   2'h2

// ------------------------------------------------------------------
// Status and counter register fields
// ------------------------------------------------------------------
`define FSU_ST_START       7
`define FSU_ST_OVF         6
`define FSU_ST_STOP        5
`define FSU_ST_COLL        4
`define FSU_ST_CNT_HI      3
`define FSU_ST_CNT_LO      0

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define FSU_CR_SIE         7
`define FSU_CR_OIE         6
`define FSU_CR_WM_HI       5
`define FSU_CR_WM_LO       4
`define FSU_CR_CS_HI       3
`define FSU_CR_CS_LO       2
`define FSU_CR_CLK         1
`define FSU_CR_TC          0

// ------------------------------------------------------------------
// Wire modes and clock sources
// ------------------------------------------------------------------
`define FSU_WM_OFF         2'h0
`define FSU_WM_THREE       2'h1
`define FSU_WM_TWO         2'h2
`define FSU_WM_TWO_HOLD    2'h3
`define FSU_CS_SOFT        2'h0
`define FSU_CS_TIMER       2'h1
`define FSU_CS_EXT_RISE    2'h2
`define FSU_CS_EXT_FALL    2'h3

// ------------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------------
`define FSU_DATA_RST       8'h00
`define FSU_CNT_RST        4'h0
`define FSU_CNT_MAX        4'hf
`define FSU_WM_RST         2'h0
`define FSU_CS_RST         2'h0
`define FSU_RDATA_IDLE     8'h00
`define FSU_CLK_DIV_MIN    4

`endif

/* File: fsu_pin_sync.v */
// Two-stage pin synchroniser with rising and falling edge detection.
`timescale 1ns/1ps

module fsu_pin_sync #(
  parameter WIDTH = 2
) (
  input  wire             mclk,
  input  wire             reset,
  input  wire [WIDTH-1:0] pin_async,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise,
  output wire [WIDTH-1:0] fall
);

  // ------------------------------------------------------------------
  // One synchroniser and edge detector per pin
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_pin
      reg stage1_r;
      reg stage2_r;
      reg prev_r;

      // Only the second stage reads the first; edges come from stage two.
      always @(posedge mclk)
      begin
        if (reset)
        begin
          stage1_r <= 1'b1;
          stage2_r <= 1'b1;
          prev_r   <= 1'b1;
        end
        else
        begin
          stage1_r <= pin_async[g];
          stage2_r <= stage1_r;
          prev_r   <= stage2_r;
        end
      end

      // Edge pulses last one cycle each.
      assign level[g] = stage2_r;
      assign rise[g]  = stage2_r & ~prev_r;
      assign fall[g]  = ~stage2_r & prev_r;
    end
  endgenerate

endmodule

/* File: fsu_flexible_serial_unit.v */
// Flexible serial unit: shift register, 4-bit counter, flags, pin control.
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fsu_consts.vh"

// Summary of operation
// - Serial clock at most a quarter of mclk.
// - Two-wire slave holds clock low until ready.
// - External clock counts on both edges.
// - Counter cascades with timer zero compare.
// - Counter preset to max overflows next edge.
// - Data write wins over a coinciding shift.
// - Shift left from input, clock chosen by source.
// - Inputs work even with wire mode off.
// - Output from data bit seven, direction gated.
// - Latch half-open external, always open internal.
// - Open latch passes new top bit immediately.
// - Start flag: start condition, else each count.
// - Start request when flag and enables set.
// - Start flag cleared by one, releases hold.
// - Overflow flag on wrap, cleared by one.
// - Overflow request gated by enables, idle wake.
// - Stop flag on stop condition, no request.
// - Collision reads shift bit seven versus pin.
// - Low status bits are counter, writable.
// - External source plus clock bit: toggle counts.
// - Overflow enable gates overflow request.
// - Hold mode keeps clock low while overflowed.
module fsu_flexible_serial_unit (
  input  wire       mclk,
  input  wire       reset,
  input  wire [1:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output wire [7:0] reg_rdata,
  input  wire       serial_in_pin,
  input  wire       serial_clock_pin,
  input  wire       timer0_match,
  input  wire       global_int_enable,
  input  wire       do_dir,
  input  wire       sda_dir,
  input  wire       sda_port_bit,
  input  wire       scl_dir,
  input  wire       scl_port_bit,
  output wire       do_out,
  output wire       do_oe_n,
  output wire       sda_out,
  output wire       sda_oe_n,
  output wire       scl_out,
  output wire       scl_oe_n,
  output wire       start_irq,
  output wire       overflow_irq,
  output wire       counter_wrap,
  output wire       clock_toggle
);

  // ------------------------------------------------------------------
  // Start hold states
  // ------------------------------------------------------------------
  localparam [2:0] HOLD_IDLE  = 3'h1;
  localparam [2:0] HOLD_ARMED = 3'h2;
  localparam [2:0] HOLD_LOW   = 3'h4;

  // ------------------------------------------------------------------
  // Address decode helper
  // ------------------------------------------------------------------
  function hit;
    input [1:0] addr;
    input [1:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  reg [7:0] shift_r;
  reg [7:0] shift_nxt;
  reg [3:0] clock_count_r;
  reg [3:0] clock_count_nxt;
  reg       start_flag_r;
  reg       overflow_flag_r;
  reg       stop_flag_r;
  reg       start_interrupt_enable_r;
  reg       overflow_interrupt_enable_r;
  reg [1:0] wire_mode_select_r;
  reg [1:0] clock_source_select_r;
  reg       ext_soft_count_r;
  reg       out_latch_r;
  reg [2:0] hold_state_r;
  reg [2:0] hold_state_nxt;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg       counter_wrap_r;
  reg       clock_toggle_r;
  reg       shift_clk;
  reg       count_clk;

  wire       wr_data;
  wire       wr_status;
  wire       wr_control;
  wire       clk_strobe;
  wire       tc_strobe;
  wire [1:0] cs_eff;
  wire       ext_soft_eff;
  wire       two_wire;
  wire       count_inc;
  wire       start_det;
  wire       stop_det;
  wire       start_set;
  wire       overflow_set;
  wire       stop_set;
  wire       start_clear;
  wire       overflow_clear;
  wire       stop_clear;
  wire       latch_open;
  wire       out_bit;
  wire       collision;
  wire       start_hold;
  wire       overflow_hold;
  wire [1:0] pin_level;
  wire [1:0] pin_rise;
  wire [1:0] pin_fall;
  wire       sda_lvl;
  wire       scl_lvl;

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  // Edges need the pin to stay put for two mclk cycles, which limits the
  // serial clock to a quarter of mclk.
  fsu_pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .mclk      (mclk),
    .reset     (reset),
    .pin_async ({serial_clock_pin, serial_in_pin}),
    .level     (pin_level),
    .rise      (pin_rise),
    .fall      (pin_fall)
  );

  assign sda_lvl = pin_level[0];
  assign scl_lvl = pin_level[1];

  // ------------------------------------------------------------------
  // Register strobes
  // ------------------------------------------------------------------
  // Strobes act in their own write, so that write's clock
  // source is used, not the stored one.
  assign wr_data      = reg_wr & hit(reg_addr, `FSU_ADDR_DATA);
  assign wr_status    = reg_wr & hit(reg_addr, `FSU_ADDR_STATUS);
  assign wr_control   = reg_wr & hit(reg_addr, `FSU_ADDR_CONTROL);
  assign clk_strobe   = wr_control & reg_wdata[`FSU_CR_CLK];
  assign tc_strobe    = wr_control & reg_wdata[`FSU_CR_TC];
  assign cs_eff       = wr_control ? reg_wdata[`FSU_CR_CS_HI:`FSU_CR_CS_LO]
                                   : clock_source_select_r;
  assign ext_soft_eff = wr_control ? (reg_wdata[`FSU_CR_CLK] & reg_wdata[`FSU_CR_CS_HI])
                                   : ext_soft_count_r;
  assign two_wire     = wire_mode_select_r[1];

  // ------------------------------------------------------------------
  // Clock selection for shifter and counter
  // ------------------------------------------------------------------
  // Pin clocks ignore the wire mode, so inputs stay
  // usable with outputs disabled.
  always @*
  begin
    shift_clk = 1'b0;
    count_clk = 1'b0;
    case (cs_eff)
      `FSU_CS_SOFT:
      begin
        shift_clk = clk_strobe;
        count_clk = clk_strobe;
      end
      `FSU_CS_TIMER:
      begin
        shift_clk = timer0_match;
        count_clk = timer0_match;
      end
      `FSU_CS_EXT_RISE:
      begin
        shift_clk = pin_rise[1];
        count_clk = ext_soft_eff ? tc_strobe
                                 : (pin_rise[1] | pin_fall[1]);
      end
      `FSU_CS_EXT_FALL:
      begin
        shift_clk = pin_fall[1];
        count_clk = ext_soft_eff ? tc_strobe
                                 : (pin_rise[1] | pin_fall[1]);
      end
      default:
      begin
        shift_clk = 1'b0;
        count_clk = 1'b0;
      end
    endcase
  end

  // A status write loads the counter and swallows a coinciding count.
  assign count_inc = count_clk & ~wr_status;

  // ------------------------------------------------------------------
  // Shift register and counter next values
  // ------------------------------------------------------------------
  always @*
  begin
    shift_nxt = shift_r;
    if (wr_data)
    begin
      shift_nxt = reg_wdata;
    end
    else if (shift_clk)
    begin
      shift_nxt = {shift_r[6:0], sda_lvl};
    end
  end

  always @*
  begin
    clock_count_nxt = clock_count_r;
    if (wr_status)
    begin
      clock_count_nxt = reg_wdata[`FSU_ST_CNT_HI:`FSU_ST_CNT_LO];
    end
    else if (count_inc)
    begin
      clock_count_nxt = clock_count_r + 4'h1;
    end
  end

  // ------------------------------------------------------------------
  // Bus conditions and flag events
  // ------------------------------------------------------------------
  // Data moving while the clock line is high marks start or stop.
  assign start_det      = two_wire & scl_lvl & pin_fall[0];
  assign stop_det       = two_wire & scl_lvl & pin_rise[0];
  assign start_set      = two_wire ? start_det : count_inc;
  assign overflow_set   = count_inc & (clock_count_r == `FSU_CNT_MAX);
  assign stop_set       = stop_det;
  assign start_clear    = wr_status & reg_wdata[`FSU_ST_START];
  assign overflow_clear = wr_status & reg_wdata[`FSU_ST_OVF];
  assign stop_clear     = wr_status & reg_wdata[`FSU_ST_STOP];

  // ------------------------------------------------------------------
  // Start hold state machine
  // ------------------------------------------------------------------
  // A start arms the hold; the next falling clock engages
  // it until software clears the start flag.
  always @*
  begin
    hold_state_nxt = hold_state_r;
    case (hold_state_r)
      HOLD_IDLE:
      begin
        if (start_det)
        begin
          hold_state_nxt = HOLD_ARMED;
        end
      end
      HOLD_ARMED:
      begin
        if (start_clear & ~start_det)
        begin
          hold_state_nxt = HOLD_IDLE;
        end
        else if (pin_fall[1])
        begin
          hold_state_nxt = HOLD_LOW;
        end
      end
      HOLD_LOW:
      begin
        if (start_clear)
        begin
          hold_state_nxt = start_det ? HOLD_ARMED : HOLD_IDLE;
        end
      end
      default:
      begin
        hold_state_nxt = HOLD_IDLE;
      end
    endcase
    if (~two_wire)
    begin
      hold_state_nxt = HOLD_IDLE;
    end
  end

  // ------------------------------------------------------------------
  // Output latch and pin drive
  // ------------------------------------------------------------------
  // An external clock opens the latch only in the half period
  // before the shifting edge, so output and sampling use opposite edges.
  assign latch_open    = ~clock_source_select_r[1] |
                         (scl_lvl == clock_source_select_r[0]);
  assign out_bit       = latch_open ? shift_r[7] : out_latch_r;
  assign collision     = shift_r[7] ^ sda_lvl;
  assign start_hold    = (hold_state_r == HOLD_LOW);
  assign overflow_hold = (wire_mode_select_r == `FSU_WM_TWO_HOLD) & overflow_flag_r;

  // Open-drain lines only ever pull low; enables are active low.
  assign do_out   = out_bit;
  assign do_oe_n  = ~(do_dir & (wire_mode_select_r == `FSU_WM_THREE));
  assign sda_out  = 1'b0;
  assign sda_oe_n = ~(two_wire & sda_dir & (~out_bit | ~sda_port_bit));
  assign scl_out  = 1'b0;
  assign scl_oe_n = ~(two_wire & scl_dir &
                      (~scl_port_bit | start_hold | overflow_hold));

  // ------------------------------------------------------------------
  // Requests to the interrupt controller
  // ------------------------------------------------------------------
  // Plain gating of stored flags: a pending flag requests
  // as soon as the last enable comes on. Start may wake from
  // any sleep mode, overflow only from idle.
  assign start_irq    = start_flag_r & start_interrupt_enable_r &
                        global_int_enable;
  assign overflow_irq = overflow_flag_r & overflow_interrupt_enable_r &
                        global_int_enable;
  assign counter_wrap = counter_wrap_r;
  assign clock_toggle = clock_toggle_r;

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  // Strobe bits read as zero; an unmapped offset reads zero.
  always @*
  begin
    rdata_nxt = `FSU_RDATA_IDLE;
    if (reg_rd)
    begin
      case (reg_addr)
        `FSU_ADDR_DATA:
        begin
          rdata_nxt = shift_r;
        end
        `FSU_ADDR_STATUS:
        begin
          rdata_nxt = {start_flag_r, overflow_flag_r, stop_flag_r,
                       collision, clock_count_r};
        end
        `FSU_ADDR_CONTROL:
        begin
          rdata_nxt = {start_interrupt_enable_r, overflow_interrupt_enable_r,
                       wire_mode_select_r, clock_source_select_r, 2'h0};
        end
        default:
        begin
          rdata_nxt = `FSU_RDATA_IDLE;
        end
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Every flag lets a set win over a clear in the same cycle.
  always @(posedge mclk)
  begin
    if (reset)
    begin
      shift_r                     <= `FSU_DATA_RST;
      clock_count_r               <= `FSU_CNT_RST;
      start_flag_r                <= 1'b0;
      overflow_flag_r             <= 1'b0;
      stop_flag_r                 <= 1'b0;
      start_interrupt_enable_r    <= 1'b0;
      overflow_interrupt_enable_r <= 1'b0;
      wire_mode_select_r          <= `FSU_WM_RST;
      clock_source_select_r       <= `FSU_CS_RST;
      ext_soft_count_r            <= 1'b0;
      out_latch_r                 <= 1'b0;
      hold_state_r                <= HOLD_IDLE;
      rdata_r                     <= `FSU_RDATA_IDLE;
      counter_wrap_r              <= 1'b0;
      clock_toggle_r              <= 1'b0;
    end
    else
    begin
      shift_r         <= shift_nxt;
      clock_count_r   <= clock_count_nxt;
      start_flag_r    <= start_set | (start_flag_r & ~start_clear);
      overflow_flag_r <= overflow_set | (overflow_flag_r & ~overflow_clear);
      stop_flag_r     <= stop_set | (stop_flag_r & ~stop_clear);
      if (wr_control)
      begin
        start_interrupt_enable_r    <= reg_wdata[`FSU_CR_SIE];
        overflow_interrupt_enable_r <= reg_wdata[`FSU_CR_OIE];
        wire_mode_select_r          <= reg_wdata[`FSU_CR_WM_HI:`FSU_CR_WM_LO];
        clock_source_select_r       <= reg_wdata[`FSU_CR_CS_HI:`FSU_CR_CS_LO];
        ext_soft_count_r            <= ext_soft_eff;
      end
      if (latch_open)
      begin
        out_latch_r <= shift_r[7];
      end
      hold_state_r   <= hold_state_nxt;
      rdata_r        <= rdata_nxt;
      counter_wrap_r <= overflow_set;
      clock_toggle_r <= tc_strobe & ~cs_eff[1];
    end
  end

endmodule

/* File: fsu_flexible_serial_unit_assertions.sv */
// Port-level assertions of the serial unit.
`timescale 1ns/1ps
`include "fsu_consts.vh"

module fsu_unit_checker (
  input wire       mclk,
  input wire       reset,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       global_int_enable,
  input wire       do_dir,
  input wire       sda_dir,
  input wire       scl_dir,
  input wire       do_oe_n,
  input wire       sda_out,
  input wire       sda_oe_n,
  input wire       scl_out,
  input wire       scl_oe_n,
  input wire       start_irq,
  input wire       overflow_irq,
  input wire       counter_wrap,
  input wire       clock_toggle
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Read data is idle except in the cycle after a read strobe.
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == `FSU_RDATA_IDLE)
    else $error("stray read data");
  a_start_gate: assert property (start_irq |-> global_int_enable)
    else $error("start request ungated");
  a_ovf_gate: assert property (overflow_irq |-> global_int_enable)
    else $error("overflow request ungated");
  // Flags clear only by a write, so a request never vanishes on its own.
  a_ovf_sticky: assert property ($past(overflow_irq) && !$past(reg_wr) && global_int_enable
    |-> overflow_irq) else $error("overflow request dropped");
  a_start_sticky: assert property ($past(start_irq) && !$past(reg_wr) && global_int_enable
    |-> start_irq) else $error("start request dropped");
  a_wrap_pulse: assert property (counter_wrap |=> !counter_wrap)
    else $error("long wrap pulse");
  a_pin_dir: assert property ((do_oe_n || do_dir) && (sda_oe_n || sda_dir)
    && (scl_oe_n || scl_dir)) else $error("pin driven against direction");
  a_open_drain: assert property (sda_out == 1'b0 && scl_out == 1'b0)
    else $error("open drain driven high");
  a_toggle_cause: assert property (clock_toggle |-> $past(reg_wr)
    && $past(reg_addr) == `FSU_ADDR_CONTROL && ($past(reg_wdata) & 8'h01) == 8'h01)
    else $error("toggle without strobe");
  a_reset_quiet: assert property ($fell(reset) |-> do_oe_n && sda_oe_n && scl_oe_n
    && !start_irq && !overflow_irq) else $error("active after reset");

  c_wrap: cover property (counter_wrap);
  c_ovf: cover property (overflow_irq);
  c_hold: cover property (!scl_oe_n ##1 scl_oe_n);
  c_toggle: cover property (clock_toggle);
endmodule

bind fsu_flexible_serial_unit fsu_unit_checker u_checker (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .global_int_enable(global_int_enable), .do_dir(do_dir), .sda_dir(sda_dir),
  .scl_dir(scl_dir), .do_oe_n(do_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .start_irq(start_irq),
  .overflow_irq(overflow_irq), .counter_wrap(counter_wrap), .clock_toggle(clock_toggle)
);

/* File: fsu_spi_partner.sv */
// Serial master model on the pin side of the serial unit.
`timescale 1ns/1ps

module fsu_spi_partner (
  input  wire do_line,
  output reg  sck,
  output reg  sdi
);
  // Half the 800 ns link period: four mclk per level.
  localparam HALF = 400;

  initial
  begin
    sck = 1'b0;
    sdi = 1'b1;
  end

  // Data line only; the clock stands still.
  task put(input b);
    sdi = b;
  endtask

  // One byte MSB first on rising clock; data then inverted.
  task send(input [7:0] b, output [7:0] got);
    integer k;
    for (k = 7; k >= 0; k = k - 1)
    begin
      sdi = b[k];
      #HALF sck = 1'b1;
      got[k] = do_line;
      #HALF sck = 1'b0;
    end
    sdi = ~b[0];
    #HALF;
  endtask

  // Data falls with the clock high, then clock low.
  task start_cond;
    sdi = 1'b1;
    #HALF sck = 1'b1;
    #HALF sdi = 1'b0;
    #HALF sck = 1'b0;
    #HALF;
  endtask

  // Data rises while the clock is high.
  task stop_cond;
    sck = 1'b1;
    #HALF sdi = 1'b1;
    #HALF;
  endtask
endmodule

/* File: fsu_flexible_serial_unit_test.sv */
// Self-checking bench of the flexible serial unit.
`timescale 1ns/1ps
`include "fsu_consts.vh"

module fsu_flexible_serial_unit_test;
  reg         mclk, reset, reg_wr, reg_rd, timer0_match, global_int_enable, b;
  reg  [1:0]  reg_addr;
  reg  [7:0]  reg_wdata, exp_data, exp_cnt, got, cr;
  reg  [31:0] rnd;
  wire [7:0]  reg_rdata;
  wire        do_out, do_oe_n, sda_oe_n, scl_oe_n, pm_sck, pm_sdi;
  wire        start_irq, overflow_irq, counter_wrap, clock_toggle;
  integer     errors, check_count, i, w0;
  integer     wraps = 0, toggles = 0;

  // Open drain: a line is low if either side pulls it.
  fsu_flexible_serial_unit uut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_in_pin(pm_sdi & sda_oe_n), .serial_clock_pin(pm_sck & scl_oe_n),
    .timer0_match(timer0_match), .global_int_enable(global_int_enable),
    .do_dir(1'b1), .sda_dir(1'b1), .sda_port_bit(1'b1), .scl_dir(1'b1),
    .scl_port_bit(1'b1), .do_out(do_out), .do_oe_n(do_oe_n), .sda_out(),
    .sda_oe_n(sda_oe_n), .scl_out(), .scl_oe_n(scl_oe_n), .start_irq(start_irq),
    .overflow_irq(overflow_irq), .counter_wrap(counter_wrap), .clock_toggle(clock_toggle)
  );
  fsu_spi_partner pm (.do_line(do_out), .sck(pm_sck), .sdi(pm_sdi));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Count pulses so that none is missed.
  always @(posedge mclk)
  begin
    if (counter_wrap === 1'b1) wraps <= wraps + 1;
    if (clock_toggle === 1'b1) toggles <= toggles + 1;
  end

  task chk(input [7:0] g, input [7:0] e, input string what);
    check_count = check_count + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("BAD %0t %s got %h want %h", $time, what, g, e);
    end
  endtask

  task chb(input g, input e, input string what);
    chk({7'h0, g}, {7'h0, e}, what);
  endtask

  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask

  task wr(input [1:0] a, input [7:0] d, input t);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    timer0_match <= t;
    @(posedge mclk);
    reg_wr <= 1'b0;
    timer0_match <= 1'b0;
  endtask

  // Data is taken in the cycle after the strobe.
  task rd(input [1:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    got = reg_rdata;
  endtask

  // Software clock strobe once the bit is through the synchroniser.
  task sw_shift(input bit_in);
    pm.put(bit_in);
    tick(4);
    wr(`FSU_ADDR_CONTROL, cr | 8'h02, 1'b0);
    exp_data = {exp_data[6:0], bit_in};
    exp_cnt = (exp_cnt + 8'h01) & 8'h0f;
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A hang counts as a mismatch.
  initial
  begin
    #2000000;
    errors = errors + 1;
    $display("BAD %0t timeout", $time);
    summarize;
  end

  initial
  begin
    reset = 1'b1;
    {reg_wr, reg_rd, timer0_match, global_int_enable} = 4'h0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    errors = 0;
    check_count = 0;
    void'($urandom(50));
    tick(20);
    reset <= 1'b0;
    // Reset values; collision sees the idle-high data line.
    rd(`FSU_ADDR_DATA); chk(got, `FSU_DATA_RST, "data reset");
    rd(`FSU_ADDR_STATUS); chk(got, 8'h10, "status reset");
    rd(`FSU_ADDR_CONTROL); chk(got, 8'h00, "control reset");
    wr(2'h3, 8'hff, 1'b0);
    rd(2'h3); chk(got, `FSU_RDATA_IDLE, "unmapped read");
    $display("test reset done");
    // Software strobes shift and count.
    cr = 8'h10;
    wr(`FSU_ADDR_CONTROL, cr, 1'b0);
    rnd = $urandom;
    exp_data = rnd[7:0];
    wr(`FSU_ADDR_DATA, exp_data, 1'b0);
    tick(1); chb(do_out, exp_data[7], "new top bit");
    wr(`FSU_ADDR_STATUS, 8'he0, 1'b0);
    exp_cnt = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      b = rnd[8 + i];
      sw_shift(b);
      tick(1); chb(do_out, exp_data[7], "serial out");
    end
    rd(`FSU_ADDR_DATA); chk(got, exp_data, "shifted data");
    rd(`FSU_ADDR_STATUS); chk(got, {3'h4, exp_data[7] ^ b, exp_cnt[3:0]}, "status");
    rd(`FSU_ADDR_CONTROL); chk(got, cr, "strobes read zero");
    $display("test software shift done");
    // Start request gating and clearing.
    global_int_enable <= 1'b1;
    wr(`FSU_ADDR_CONTROL, 8'h90, 1'b0);
    tick(1); chb(start_irq, 1'b1, "start request");
    wr(`FSU_ADDR_STATUS, 8'h00, 1'b0);
    tick(1); chb(start_irq, 1'b1, "zero write");
    wr(`FSU_ADDR_STATUS, 8'h80, 1'b0);
    tick(1); chb(start_irq, 1'b0, "start cleared");
    $display("test start request done");
    // A preset maximum overflows on the next count.
    cr = 8'h50;
    wr(`FSU_ADDR_CONTROL, cr, 1'b0);
    wr(`FSU_ADDR_STATUS, 8'hef, 1'b0);
    exp_cnt = 8'h0f;
    w0 = wraps;
    sw_shift(rnd[16]);
    tick(2); chk(wraps - w0, 8'h01, "wrap pulse");
    chb(overflow_irq, 1'b1, "overflow request");
    rd(`FSU_ADDR_STATUS); chk(got & 8'h4f, 8'h40, "overflow flag");
    global_int_enable <= 1'b0;
    tick(1); chb(overflow_irq, 1'b0, "global gate");
    global_int_enable <= 1'b1;
    wr(`FSU_ADDR_STATUS, 8'h00, 1'b0);
    tick(1); chb(overflow_irq, 1'b1, "pending");
    wr(`FSU_ADDR_STATUS, 8'h40, 1'b0);
    tick(1); chb(overflow_irq, 1'b0, "overflow cleared");
    $display("test overflow done");
    // Timer compare shifts; a coinciding data write wins.
    cr = 8'h14;
    wr(`FSU_ADDR_CONTROL, cr, 1'b0);
    pm.put(rnd[17]);
    tick(4);
    timer0_match <= 1'b1;
    tick(1);
    timer0_match <= 1'b0;
    exp_data = {exp_data[6:0], rnd[17]};
    rd(`FSU_ADDR_DATA); chk(got, exp_data, "timer shift");
    exp_data = rnd[31:24];
    wr(`FSU_ADDR_DATA, exp_data, 1'b1);
    rd(`FSU_ADDR_DATA); chk(got, exp_data, "write wins");
    $display("test timer shift done");
    // External clock: one byte each way, 16 counted edges.
    wr(`FSU_ADDR_CONTROL, 8'h18, 1'b0);
    rnd = $urandom;
    wr(`FSU_ADDR_DATA, rnd[7:0], 1'b0);
    wr(`FSU_ADDR_STATUS, 8'he0, 1'b0);
    pm.send(rnd[15:8], got); chk(got, rnd[7:0], "byte out");
    chb(do_oe_n, 1'b0, "do driven");
    rd(`FSU_ADDR_DATA); chk(got, rnd[15:8], "byte in");
    rd(`FSU_ADDR_STATUS); chk(got & 8'hcf, 8'hc0, "16 edges");
    wr(`FSU_ADDR_STATUS, 8'he0, 1'b0);
    wr(`FSU_ADDR_CONTROL, 8'h1b, 1'b0);
    rd(`FSU_ADDR_STATUS); chk(got & 8'h0f, 8'h01, "toggle counts");
    w0 = toggles;
    wr(`FSU_ADDR_CONTROL, 8'h11, 1'b0);
    tick(2); chk(toggles - w0, 8'h01, "toggle pulse");
    $display("test external clock done");
    // Two-wire start hold, stop flag and overflow hold.
    wr(`FSU_ADDR_DATA, 8'hff, 1'b0);
    wr(`FSU_ADDR_CONTROL, 8'h20, 1'b0);
    wr(`FSU_ADDR_STATUS, 8'he0, 1'b0);
    pm.start_cond;
    tick(2); chb(scl_oe_n, 1'b0, "start hold");
    rd(`FSU_ADDR_STATUS); chk(got & 8'ha0, 8'h80, "start seen");
    wr(`FSU_ADDR_STATUS, 8'h80, 1'b0);
    tick(1); chb(scl_oe_n, 1'b1, "hold released");
    pm.stop_cond;
    rd(`FSU_ADDR_STATUS); chk(got & 8'ha0, 8'h20, "stop seen");
    wr(`FSU_ADDR_CONTROL, 8'h30, 1'b0);
    wr(`FSU_ADDR_STATUS, 8'hef, 1'b0);
    wr(`FSU_ADDR_CONTROL, 8'h32, 1'b0);
    tick(1); chb(scl_oe_n, 1'b0, "overflow hold");
    wr(`FSU_ADDR_STATUS, 8'h40, 1'b0);
    tick(1); chb(scl_oe_n, 1'b1, "ovf released");
    $display("test two-wire done");
    summarize;
  end
endmodule
